// [shared/rpc_defines.svh]
`ifndef RPC_DEFINES_SVH
`define RPC_DEFINES_SVH

// ****************************************************************
// Register byte offsets on the host bus
// ****************************************************************
`define RPC_OFS_PTR_UPPER  3'h2
`define RPC_OFS_PTR_LOWER  3'h3
`define RPC_OFS_RAM_DATA   3'h4
`define RPC_OFS_CONFIG     3'h6
`define RPC_OFS_INDIRECT   3'h7

// ****************************************************************
// Upper pointer register fields
// ****************************************************************
`define RPC_UP_RD_DIR      7
`define RPC_UP_STEP        6
`define RPC_UP_ADDR_HI     2
`define RPC_UP_ADDR_LO     0
`define RPC_UP_WMASK       8'hc7
`define RPC_PTR_RST        8'h00

// ****************************************************************
// Configuration register fields
// ****************************************************************
`define RPC_CFG_SRST       7
`define RPC_CFG_CHAIN      6
`define RPC_CFG_TRANSMIT_DRIVE_ENABLE       5
`define RPC_CFG_ET_HI      4
`define RPC_CFG_ET_LO      3
`define RPC_CFG_BKPL       2
`define RPC_CFG_SUB_HI     1
`define RPC_CFG_SUB_LO     0
`define RPC_CFG_RST        8'h00

// ****************************************************************
// Timeout scale patterns and indirect register selections
// ****************************************************************
`define RPC_ET_BASE        2'h0
`define RPC_ET_HALF        2'h1
`define RPC_ET_QUARTER     2'h2
`define RPC_ET_FAST        2'h3
`define RPC_ET_HALF_SHIFT  1
`define RPC_ET_QUART_SHIFT 2
`define RPC_SUB_TENT_ID    2'h0
`define RPC_SUB_NODE_ID    2'h1
`define RPC_SUB_SETUP      2'h2
`define RPC_SUB_NEXT_ID    2'h3

// ****************************************************************
// Protocol times and clock period
// ****************************************************************
`define RPC_CLK_PERIOD_NS  4
`define RPC_NS_PER_US      1000
`define RPC_NS_PER_MS      1000000
`define RPC_RESP_TIME_NS   1193600
`define RPC_IDLE_TIME_US   1312
`define RPC_RECON_TIME_MS  1680
`define RPC_RESP_FAST_NS   74700
`define RPC_IDLE_FAST_US   82
`define RPC_RECON_FAST_MS  840

`endif

// [shared/rpc_pkg.sv]
package rpc_pkg;

  // Host bus addresses and data bytes.
  typedef logic [2:0]  rpc_addr_t;
  typedef logic [7:0]  rpc_byte_t;
  typedef logic [10:0] rpc_ram_addr_t;
  typedef logic [31:0] rpc_cycles_t;

  // Host end sequencer states.
  typedef enum logic [0:0]
  {
    RPC_IDLE = 1'b0,
    RPC_WAIT = 1'b1
  } rpc_state_t;

endpackage : rpc_pkg

// [shared/rpc_bus_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Parallel register bus between the host and the device, both on sys_clk.
interface rpc_bus_if;
  logic [2:0] bus_addr;
  logic [7:0] bus_wdata;
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_rdata;
  logic       bus_rvalid;

  modport dev
  (
    input  bus_addr,
    input  bus_wdata,
    input  bus_wr,
    input  bus_rd,
    output bus_rdata,
    output bus_rvalid
  );

  modport host
  (
    output bus_addr,
    output bus_wdata,
    output bus_wr,
    output bus_rd,
    input  bus_rdata,
    input  bus_rvalid
  );
endinterface : rpc_bus_if

`default_nettype wire

// [hdl/rpc_dev.sv]
// Operation
// - Read-direction bit picks next RAM access type
// - Step enable advances pointer after each access
// - Upper pointer low bits give address top
// - Lower pointer gives address low byte
// - Upper pointer bits five to three undefined
// - Reset bit holds soft reset until cleared
// - Soft reset keeps configuration and interface mode
// - Soft reset touches status, next id, diagnostics
// - Linking bit enables chained command operation
// - Transmit enable gates pulse and driver outputs; pulse B is left ungated while the backplane bit is set
// - Transmit enable reads zero after reset
// - Software sets transmit enable after id settles
// - Base timeouts 1193.6us, 1312us, 1680ms
// - Scale 01 halves, 10 quarters; reconfig unchanged
// - Scale 11 gives 74.7us, 82us, 840ms
// - All nodes use identical timeout scale settings
// - Backplane bit selects open-drain/differential signalling
// - Sub-address selects register seen at 07
`timescale 1ns/1ps
`include "rpc_defines.svh"
`default_nettype none

module rpc_dev
#(
  parameter int RESP_BASE_CYC  = `RPC_RESP_TIME_NS / `RPC_CLK_PERIOD_NS,
  parameter int IDLE_BASE_CYC  = (`RPC_IDLE_TIME_US * `RPC_NS_PER_US) / `RPC_CLK_PERIOD_NS,
  parameter int RECON_BASE_CYC = (`RPC_RECON_TIME_MS * `RPC_NS_PER_MS) / `RPC_CLK_PERIOD_NS,
  parameter int RESP_FAST_CYC  = `RPC_RESP_FAST_NS / `RPC_CLK_PERIOD_NS,
  parameter int IDLE_FAST_CYC  = (`RPC_IDLE_FAST_US * `RPC_NS_PER_US) / `RPC_CLK_PERIOD_NS,
  parameter int RECON_FAST_CYC = (`RPC_RECON_FAST_MS * `RPC_NS_PER_MS) / `RPC_CLK_PERIOD_NS
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  rpc_bus_if.dev                     bus,
  output logic                       soft_reset,
  output logic                       cmd_linking_enable,
  output logic                       transmit_drive_enable,
  output logic [1:0]                 timeout_scale_sel,
  output logic                       direct_media_signalling,
  output logic [1:0]                 indirect_reg_select,
  output rpc_pkg::rpc_ram_addr_t     ram_addr,
  output logic                       ram_wr_en,
  output rpc_pkg::rpc_ram_addr_t     ram_wr_addr,
  output rpc_pkg::rpc_byte_t         ram_wdata,
  output logic                       ram_rd_en,
  input  wire rpc_pkg::rpc_byte_t    ram_rdata,
  output logic                       ind_wr_en,
  output rpc_pkg::rpc_byte_t         ind_wdata,
  input  wire rpc_pkg::rpc_byte_t    ind_rdata,
  input  wire logic                  tx_pulse_a_req,
  input  wire logic                  tx_pulse_b_req,
  input  wire logic                  tx_line_drv_req,
  output logic                       media_pulse_a,
  output logic                       media_pulse_b,
  output logic                       line_driver_on,
  output rpc_pkg::rpc_cycles_t       resp_timeout_cyc,
  output rpc_pkg::rpc_cycles_t       idle_timeout_cyc,
  output rpc_pkg::rpc_cycles_t       recon_timeout_cyc
);
  import rpc_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  rpc_byte_t     up_q,       up_d;
  rpc_byte_t     lo_q,       lo_d;
  rpc_byte_t     cfg_q,      cfg_d;
  rpc_byte_t     rdata_q,    rdata_d;
  logic          rvalid_q,   rvalid_d;
  logic          wr_en_q,    wr_en_d;
  rpc_ram_addr_t wr_addr_q,  wr_addr_d;
  rpc_byte_t     wdata_q,    wdata_d;
  logic          rd_en_q,    rd_en_d;
  logic          ind_wr_q,   ind_wr_d;
  rpc_byte_t     ind_wd_q,   ind_wd_d;
  rpc_ram_addr_t ptr;
  rpc_ram_addr_t ptr_next;
  logic          access;

  // The pointer is the three upper bits stacked over the lower byte.
  assign ptr      = {up_q[`RPC_UP_ADDR_HI:`RPC_UP_ADDR_LO], lo_q};
  assign ptr_next = ptr + 11'h001;

  // Bus decode; a write and a read in the same cycle lets the write win.
  always_comb
  begin
    up_d      = up_q;
    lo_d      = lo_q;
    cfg_d     = cfg_q;
    rdata_d   = rdata_q;
    rvalid_d  = 1'b0;
    wr_en_d   = 1'b0;
    wr_addr_d = wr_addr_q;
    wdata_d   = wdata_q;
    rd_en_d   = 1'b0;
    ind_wr_d  = 1'b0;
    ind_wd_d  = ind_wd_q;
    access    = 1'b0;
    if (bus.bus_wr)
    begin
      case (bus.bus_addr)
        `RPC_OFS_PTR_UPPER: up_d = bus.bus_wdata & `RPC_UP_WMASK;
        `RPC_OFS_PTR_LOWER: lo_d = bus.bus_wdata;
        `RPC_OFS_RAM_DATA:
        begin
          // A data write only counts while the pointer is set up for writing.
          if (!up_q[`RPC_UP_RD_DIR])
          begin
            wr_en_d   = 1'b1;
            wr_addr_d = ptr;
            wdata_d   = bus.bus_wdata;
            access    = 1'b1;
          end
        end
        `RPC_OFS_CONFIG:   cfg_d = bus.bus_wdata;
        `RPC_OFS_INDIRECT:
        begin
          ind_wr_d = 1'b1;
          ind_wd_d = bus.bus_wdata;
        end
        default: ;
      endcase
    end
    else if (bus.bus_rd)
    begin
      rvalid_d = 1'b1;
      case (bus.bus_addr)
        `RPC_OFS_PTR_UPPER: rdata_d = up_q;
        `RPC_OFS_PTR_LOWER: rdata_d = lo_q;
        `RPC_OFS_RAM_DATA:
        begin
          // Reading while set up for writing returns zero and leaves the pointer.
          if (up_q[`RPC_UP_RD_DIR])
          begin
            rdata_d = ram_rdata;
            rd_en_d = 1'b1;
            access  = 1'b1;
          end
          else
          begin
            rdata_d = 8'h00;
          end
        end
        `RPC_OFS_CONFIG:   rdata_d = cfg_q;
        `RPC_OFS_INDIRECT: rdata_d = ind_rdata;
        default:           rdata_d = 8'h00;
      endcase
    end
    // Stepping carries from the lower byte into the upper bits and wraps at 2K.
    if (access && up_q[`RPC_UP_STEP])
    begin
      up_d[`RPC_UP_ADDR_HI:`RPC_UP_ADDR_LO] = ptr_next[10:8];
      lo_d                                  = ptr_next[7:0];
    end
  end

  // Only srst clears these; the soft reset bit deliberately does not.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      up_q      <= `RPC_PTR_RST;
      lo_q      <= `RPC_PTR_RST;
      cfg_q     <= `RPC_CFG_RST;
      rdata_q   <= 8'h00;
      rvalid_q  <= 1'b0;
      wr_en_q   <= 1'b0;
      wr_addr_q <= 11'h000;
      wdata_q   <= 8'h00;
      rd_en_q   <= 1'b0;
      ind_wr_q  <= 1'b0;
      ind_wd_q  <= 8'h00;
    end
    else
    begin
      up_q      <= up_d;
      lo_q      <= lo_d;
      cfg_q     <= cfg_d;
      rdata_q   <= rdata_d;
      rvalid_q  <= rvalid_d;
      wr_en_q   <= wr_en_d;
      wr_addr_q <= wr_addr_d;
      wdata_q   <= wdata_d;
      rd_en_q   <= rd_en_d;
      ind_wr_q  <= ind_wr_d;
      ind_wd_q  <= ind_wd_d;
    end
  end

  // ****************************************************************
  // Media gating and timeout selection
  // ****************************************************************
  logic        pa_q, pa_d;
  logic        pb_q, pb_d;
  logic        ld_q, ld_d;
  rpc_cycles_t resp_q, resp_d;
  rpc_cycles_t idle_q, idle_d;
  rpc_cycles_t recon_q, recon_d;
  logic [1:0]  et;

  assign et = cfg_q[`RPC_CFG_ET_HI:`RPC_CFG_ET_LO];

  // In backplane mode the second pulse pin has its own job, so it is not gated.
  always_comb
  begin
    pa_d = tx_pulse_a_req & cfg_q[`RPC_CFG_TRANSMIT_DRIVE_ENABLE];
    pb_d = tx_pulse_b_req & (cfg_q[`RPC_CFG_TRANSMIT_DRIVE_ENABLE] | cfg_q[`RPC_CFG_BKPL]);
    ld_d = tx_line_drv_req & cfg_q[`RPC_CFG_TRANSMIT_DRIVE_ENABLE];
    case (et)
      `RPC_ET_BASE:
      begin
        resp_d  = 32'(RESP_BASE_CYC);
        idle_d  = 32'(IDLE_BASE_CYC);
        recon_d = 32'(RECON_BASE_CYC);
      end
      `RPC_ET_HALF:
      begin
        resp_d  = 32'(RESP_BASE_CYC) >> `RPC_ET_HALF_SHIFT;
        idle_d  = 32'(IDLE_BASE_CYC) >> `RPC_ET_HALF_SHIFT;
        recon_d = 32'(RECON_BASE_CYC);
      end
      `RPC_ET_QUARTER:
      begin
        resp_d  = 32'(RESP_BASE_CYC) >> `RPC_ET_QUART_SHIFT;
        idle_d  = 32'(IDLE_BASE_CYC) >> `RPC_ET_QUART_SHIFT;
        recon_d = 32'(RECON_BASE_CYC);
      end
      default:
      begin
        resp_d  = 32'(RESP_FAST_CYC);
        idle_d  = 32'(IDLE_FAST_CYC);
        recon_d = 32'(RECON_FAST_CYC);
      end
    endcase
  end

  // One cycle of latency on the media pins is the price of flop outputs.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pa_q    <= 1'b0;
      pb_q    <= 1'b0;
      ld_q    <= 1'b0;
      resp_q  <= 32'h0000_0000;
      idle_q  <= 32'h0000_0000;
      recon_q <= 32'h0000_0000;
    end
    else
    begin
      pa_q    <= pa_d;
      pb_q    <= pb_d;
      ld_q    <= ld_d;
      resp_q  <= resp_d;
      idle_q  <= idle_d;
      recon_q <= recon_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Soft reset is a level for the status, next id and diagnostic logic outside.
  assign soft_reset              = cfg_q[`RPC_CFG_SRST];
  assign cmd_linking_enable      = cfg_q[`RPC_CFG_CHAIN];
  assign transmit_drive_enable   = cfg_q[`RPC_CFG_TRANSMIT_DRIVE_ENABLE];
  assign timeout_scale_sel       = et;
  assign direct_media_signalling = cfg_q[`RPC_CFG_BKPL];
  assign indirect_reg_select     = cfg_q[`RPC_CFG_SUB_HI:`RPC_CFG_SUB_LO];
  assign ram_addr                = ptr;
  assign ram_wr_en               = wr_en_q;
  assign ram_wr_addr             = wr_addr_q;
  assign ram_wdata               = wdata_q;
  assign ram_rd_en               = rd_en_q;
  assign ind_wr_en               = ind_wr_q;
  assign ind_wdata               = ind_wd_q;
  assign media_pulse_a           = pa_q;
  assign media_pulse_b           = pb_q;
  assign line_driver_on          = ld_q;
  assign resp_timeout_cyc        = resp_q;
  assign idle_timeout_cyc        = idle_q;
  assign recon_timeout_cyc       = recon_q;
  assign bus.bus_rdata           = rdata_q;
  assign bus.bus_rvalid          = rvalid_q;

endmodule : rpc_dev

`default_nettype wire

// [hdl/rpc_host.sv]
`timescale 1ns/1ps
`include "rpc_defines.svh"
`default_nettype none

module rpc_host
(
  input  wire logic                  sys_clk,
  input  wire logic                  srst,
  rpc_bus_if.host                    bus,
  input  wire logic                  cmd_valid,
  input  wire logic                  cmd_write,
  input  wire rpc_pkg::rpc_addr_t    cmd_addr,
  input  wire rpc_pkg::rpc_byte_t    cmd_wdata,
  output logic                       cmd_ready,
  output logic                       rsp_valid,
  output rpc_pkg::rpc_byte_t         rsp_data
);
  import rpc_pkg::*;

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  rpc_state_t state_q, state_d;
  rpc_addr_t  addr_q,  addr_d;
  rpc_byte_t  wd_q,    wd_d;
  logic       wr_q,    wr_d;
  logic       rd_q,    rd_d;
  logic       rdy_q,   rdy_d;
  logic       rv_q,    rv_d;
  rpc_byte_t  rsp_q,   rsp_d;

  // Writes go back to back; a read holds off new commands until its answer.
  always_comb
  begin
    state_d = state_q;
    addr_d  = addr_q;
    wd_d    = wd_q;
    wr_d    = 1'b0;
    rd_d    = 1'b0;
    rv_d    = 1'b0;
    rsp_d   = rsp_q;
    case (state_q)
      RPC_IDLE:
      begin
        if (cmd_valid && rdy_q)
        begin
          addr_d = cmd_addr;
          wd_d   = cmd_wdata;
          if (cmd_write)
          begin
            wr_d = 1'b1;
          end
          else
          begin
            rd_d    = 1'b1;
            state_d = RPC_WAIT;
          end
        end
      end
      RPC_WAIT:
      begin
        if (bus.bus_rvalid)
        begin
          rv_d    = 1'b1;
          // Upper pointer bits five to three carry no meaning for the caller.
          rsp_d   = (addr_q == `RPC_OFS_PTR_UPPER) ? (bus.bus_rdata & `RPC_UP_WMASK) : bus.bus_rdata;
          state_d = RPC_IDLE;
        end
      end
      default: state_d = RPC_IDLE;
    endcase
    rdy_d = (state_d == RPC_IDLE);
  end

  // The bus strobes are flops so the device sees clean one-cycle pulses.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_q <= RPC_IDLE;
      addr_q  <= 3'h0;
      wd_q    <= 8'h00;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      rdy_q   <= 1'b0;
      rv_q    <= 1'b0;
      rsp_q   <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      addr_q  <= addr_d;
      wd_q    <= wd_d;
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      rdy_q   <= rdy_d;
      rv_q    <= rv_d;
      rsp_q   <= rsp_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Direction bit and timeout scale are the caller's to program; see note.
  assign bus.bus_addr  = addr_q;
  assign bus.bus_wdata = wd_q;
  assign bus.bus_wr    = wr_q;
  assign bus.bus_rd    = rd_q;
  assign cmd_ready     = rdy_q;
  assign rsp_valid     = rv_q;
  assign rsp_data      = rsp_q;

endmodule : rpc_host

`default_nettype wire

// [dv/rpc_bus_chk.sv]
`timescale 1ns/1ps
`include "rpc_defines.svh"
`default_nettype none

// ********************************
// Register bus checker
// ********************************
module rpc_bus_chk
(
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic       bus_wr,
  input wire logic       bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic       bus_rvalid
);
  logic [7:0] up_q, up_d, lo_q, lo_d, cfg_q, cfg_d;
  logic       cw_q, cw_d, stp;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  // Shadow copies; a stepping data access moves the pointer as one 11-bit count, so carries reach the upper byte.
  always_comb
  begin
    up_d = up_q;
    lo_d = lo_q;
    cfg_d = cfg_q;
    cw_d = cw_q;
    stp = bus_addr == `RPC_OFS_RAM_DATA && up_q[6] && (bus_wr ? !up_q[7] : bus_rd && up_q[7]);
    if (bus_wr && bus_addr == `RPC_OFS_PTR_UPPER) up_d = bus_wdata & `RPC_UP_WMASK;
    if (bus_wr && bus_addr == `RPC_OFS_PTR_LOWER) lo_d = bus_wdata;
    if (bus_wr && bus_addr == `RPC_OFS_CONFIG) cfg_d = bus_wdata;
    if (bus_wr && bus_addr == `RPC_OFS_CONFIG) cw_d = 1'b1;
    if (stp) {up_d[2:0], lo_d} = {up_q[2:0], lo_q} + 11'h1;
  end

  // The shadows only register here.
  always_ff @(posedge sys_clk)
  begin
    up_q <= srst ? 8'h00 : up_d;
    lo_q <= srst ? 8'h00 : lo_d;
    cfg_q <= srst ? 8'h00 : cfg_d;
    cw_q <= srst ? 1'b0 : cw_d;
  end

  property p_rv_next;
    bus_rd |=> bus_rvalid;
  endproperty
  a_rv_next: assert property (p_rv_next) else $error("read got no answer");
  property p_rv_cause;
    bus_rvalid |-> $past(bus_rd);
  endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("answer without read");
  property p_hold;
    !bus_rvalid |-> $stable(bus_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_cfg;
    bus_rd && bus_addr == `RPC_OFS_CONFIG |=> bus_rdata == $past(cfg_q);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config readback");
  property p_up;
    bus_rd && bus_addr == `RPC_OFS_PTR_UPPER |=> bus_rdata == $past(up_q);
  endproperty
  a_up: assert property (p_up) else $error("upper pointer readback");
  property p_lo;
    bus_rd && bus_addr == `RPC_OFS_PTR_LOWER |=> bus_rdata == $past(lo_q);
  endproperty
  a_lo: assert property (p_lo) else $error("lower pointer readback");
  property p_res;
    bus_rd && bus_addr == `RPC_OFS_PTR_UPPER |=> bus_rdata[5:3] == 3'h0;
  endproperty
  a_res: assert property (p_res) else $error("undefined bits stored");
  property p_transmit_drive_enable;
    bus_rd && bus_addr == `RPC_OFS_CONFIG && !cw_q |=> !bus_rdata[5];
  endproperty
  a_transmit_drive_enable: assert property (p_transmit_drive_enable) else $error("transmit on after reset");
  property p_dir;
    bus_rd && bus_addr == `RPC_OFS_RAM_DATA && !up_q[7] |=> bus_rdata == 8'h00;
  endproperty
  a_dir: assert property (p_dir) else $error("read in write direction");

  c_step: cover property (stp);
  c_wrap: cover property (stp && {up_q[2:0], lo_q} == 11'h7ff);
  c_dir: cover property (bus_rd && bus_addr == `RPC_OFS_RAM_DATA && !up_q[7]);
  c_cfg: cover property (bus_rd && bus_addr == `RPC_OFS_CONFIG && cw_q);
endmodule : rpc_bus_chk

`default_nettype wire

// [dv/ram_pointer_and_config_regs_tb.sv]
`timescale 1ns/1ps
`include "rpc_defines.svh"
`default_nettype none

// ********************************
// Bench top
// ********************************
module ram_pointer_and_config_regs_tb;
  import rpc_pkg::*;
  localparam int RSB = 64, IDB = 80, RCB = 1000, RSF = 8, IDF = 10, RCF = 500;
  logic          sys_clk, srst, cmd_valid, cmd_write, cmd_ready, rsp_valid;
  logic          soft_reset, cmd_linking_enable, transmit_drive_enable, direct_media_signalling;
  logic          ram_wr_en, ind_wr_en, media_pulse_a, media_pulse_b, line_driver_on;
  logic [1:0]    timeout_scale_sel, indirect_reg_select;
  logic [2:0]    tx_req;
  rpc_addr_t     cmd_addr;
  rpc_byte_t     cmd_wdata, rsp_data, ram_wdata, ind_wdata, ram_rdata, ind_rdata;
  rpc_ram_addr_t ram_addr, ram_wr_addr;
  rpc_cycles_t   resp_timeout_cyc, idle_timeout_cyc, recon_timeout_cyc;
  logic [7:0]    dmem [2048], mmem [2048], dind [4], mind [4];
  logic [7:0]    m_up, m_lo, m_cfg;
  logic [31:0]   r;
  int            mismatches, total_checks, i;
  logic          ram_rd_en;
  int            rd_cnt = 0;
  int            m_rd_cnt = 0;

  rpc_bus_if rpc_bus_if_i ();
  rpc_dev #(.RESP_BASE_CYC(RSB), .IDLE_BASE_CYC(IDB), .RECON_BASE_CYC(RCB),
    .RESP_FAST_CYC(RSF), .IDLE_FAST_CYC(IDF), .RECON_FAST_CYC(RCF)) rpc_dev_i (.sys_clk(sys_clk), .srst(srst),
    .bus(rpc_bus_if_i), .soft_reset(soft_reset), .cmd_linking_enable(cmd_linking_enable),
    .transmit_drive_enable(transmit_drive_enable), .timeout_scale_sel(timeout_scale_sel),
    .direct_media_signalling(direct_media_signalling), .indirect_reg_select(indirect_reg_select),
    .ram_addr(ram_addr), .ram_wr_en(ram_wr_en), .ram_wr_addr(ram_wr_addr), .ram_wdata(ram_wdata), .ram_rd_en(ram_rd_en),
    .ram_rdata(ram_rdata), .ind_wr_en(ind_wr_en), .ind_wdata(ind_wdata), .ind_rdata(ind_rdata),
    .tx_pulse_a_req(tx_req[0]), .tx_pulse_b_req(tx_req[1]), .tx_line_drv_req(tx_req[2]),
    .media_pulse_a(media_pulse_a), .media_pulse_b(media_pulse_b), .line_driver_on(line_driver_on),
    .resp_timeout_cyc(resp_timeout_cyc), .idle_timeout_cyc(idle_timeout_cyc), .recon_timeout_cyc(recon_timeout_cyc));
  rpc_host rpc_host_i (.sys_clk(sys_clk), .srst(srst), .bus(rpc_bus_if_i), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  rpc_bus_chk rpc_bus_chk_i (.sys_clk(sys_clk), .srst(srst), .bus_addr(rpc_bus_if_i.bus_addr),
    .bus_wdata(rpc_bus_if_i.bus_wdata), .bus_wr(rpc_bus_if_i.bus_wr), .bus_rd(rpc_bus_if_i.bus_rd),
    .bus_rdata(rpc_bus_if_i.bus_rdata), .bus_rvalid(rpc_bus_if_i.bus_rvalid));

  // Buffer RAM and indirect registers behind the device; reads are combinational as the device expects.
  assign ram_rdata = dmem[ram_addr];
  assign ind_rdata = dind[indirect_reg_select];
  always @(posedge sys_clk)
  begin
    if (ram_wr_en === 1'b1) dmem[ram_wr_addr] <= ram_wdata;
    if (ind_wr_en === 1'b1) dind[indirect_reg_select] <= ind_wdata;
    if (ram_rd_en === 1'b1) rd_cnt <= rd_cnt + 1;
  end

  // Free running clock.
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : chk

  // Reference model of one host access; returns the byte a read should give.
  task automatic model(input logic w, input rpc_addr_t a, input rpc_byte_t d, output rpc_byte_t e);
    e = 8'h00;
    case (a)
      `RPC_OFS_PTR_UPPER: if (w) m_up = d & `RPC_UP_WMASK; else e = m_up;
      `RPC_OFS_PTR_LOWER: if (w) m_lo = d; else e = m_lo;
      `RPC_OFS_CONFIG: if (w) m_cfg = d; else e = m_cfg;
      `RPC_OFS_INDIRECT: if (w) mind[m_cfg[1:0]] = d; else e = mind[m_cfg[1:0]];
      `RPC_OFS_RAM_DATA:
        if (w != m_up[7])
        begin
          if (w) mmem[{m_up[2:0], m_lo}] = d;
          if (!w) m_rd_cnt++;
          e = mmem[{m_up[2:0], m_lo}];
          if (m_up[6]) {m_up[2:0], m_lo} = {m_up[2:0], m_lo} + 11'h1;
        end
      default: e = 8'h00;
    endcase
  endtask : model

  // One command on the host's user side; keep leaves valid up so writes can follow back to back.
  task automatic op(input logic w, input rpc_addr_t a, input rpc_byte_t d, input bit keep);
    rpc_byte_t e;
    int        n;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(cmd_ready, 1'b1);
    @(posedge sys_clk);
    #1;
    model(w, a, d, e);
    if (!keep) cmd_valid = 1'b0;
    if (w && !keep) @(posedge sys_clk) #1;
    if (!w)
    begin
      // The answer stands in the second cycle after the take edge only.
      repeat (2) @(posedge sys_clk);
      #1;
      chk(rsp_valid, 1'b1);
      chk(rsp_data, e);
    end
  endtask : op

  // Level outputs against the model, then pin gating with random requests.
  task automatic lv();
    logic [1:0] et;
    repeat (3) @(posedge sys_clk);
    #1;
    et = m_cfg[4:3];
    chk({soft_reset, cmd_linking_enable, transmit_drive_enable, timeout_scale_sel,
      direct_media_signalling, indirect_reg_select}, m_cfg);
    chk(ram_addr, {m_up[2:0], m_lo});
    chk(rd_cnt, m_rd_cnt);
    chk(resp_timeout_cyc, (et == 2'h3) ? RSF : RSB >> et);
    chk(idle_timeout_cyc, (et == 2'h3) ? IDF : IDB >> et);
    chk(recon_timeout_cyc, (et == 2'h3) ? RCF : RCB);
    repeat (4)
    begin
      tx_req = $urandom;
      @(posedge sys_clk);
      #1;
      chk({media_pulse_a, media_pulse_b, line_driver_on}, {tx_req[0] & m_cfg[5],
        tx_req[1] & (m_cfg[5] | m_cfg[2]), tx_req[2] & m_cfg[5]});
    end
  endtask : lv

  task automatic rst(input int n);
    srst = 1'b1;
    repeat (n) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    m_up = 8'h00;
    m_lo = 8'h00;
    m_cfg = 8'h00;
  endtask : rst

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // A hang is cut short well beyond the expected run of about five hundred cycles.
  initial
  begin
    #40000;
    mismatches++;
    print_verdict();
  end

  // Main sequence.
  initial
  begin
    {cmd_valid, cmd_write, cmd_addr, cmd_wdata, tx_req} = '0;
    mismatches = 0;
    total_checks = 0;
    for (i = 0; i < 2048; i++) {dmem[i], mmem[i]} = 16'h0000;
    for (i = 0; i < 4; i++) {dind[i], mind[i]} = 16'h0000;
    r = $urandom(32'h4ee4);
    rst(8);
    lv();
    op(1'b0, `RPC_OFS_CONFIG, 8'h00, 1'b0);
    // Every timeout pattern and sub-address; transmit enable, linking and backplane bits set at random in the same write.
    // The lone node here always carries the scale that the whole network shares.
    for (i = 0; i < 16; i++)
    begin
      r = $urandom;
      op(1'b1, `RPC_OFS_CONFIG, {1'b0, r[1:0], i[1:0], r[2], i[3:2]}, 1'b0);
      lv();
      op(1'b0, `RPC_OFS_CONFIG, 8'h00, 1'b0);
      op(1'b1, `RPC_OFS_INDIRECT, r[15:8], 1'b0);
      op(1'b0, `RPC_OFS_INDIRECT, 8'h00, 1'b0);
    end
    // Back-to-back stepping writes across the top of the buffer, with undefined bits written as ones.
    op(1'b1, `RPC_OFS_PTR_UPPER, 8'h7f, 1'b0);
    op(1'b1, `RPC_OFS_PTR_LOWER, 8'hfe, 1'b0);
    for (i = 0; i < 4; i++) op(1'b1, `RPC_OFS_RAM_DATA, $urandom, i < 3);
    lv();
    op(1'b0, `RPC_OFS_PTR_UPPER, 8'h00, 1'b0);
    op(1'b1, `RPC_OFS_PTR_UPPER, 8'hc7, 1'b0);
    op(1'b1, `RPC_OFS_PTR_LOWER, 8'hfe, 1'b0);
    for (i = 0; i < 4; i++) op(1'b0, `RPC_OFS_RAM_DATA, 8'h00, 1'b0);
    // Access against the direction bit is refused, and no step without the step bit.
    op(1'b1, `RPC_OFS_RAM_DATA, 8'h5a, 1'b0);
    op(1'b1, `RPC_OFS_PTR_UPPER, 8'h47, 1'b0);
    op(1'b0, `RPC_OFS_RAM_DATA, 8'h00, 1'b0);
    op(1'b1, `RPC_OFS_PTR_UPPER, 8'h80, 1'b0);
    for (i = 0; i < 2; i++) op(1'b0, `RPC_OFS_RAM_DATA, 8'h00, 1'b0);
    lv();
    // Random traffic over all offsets, unmapped ones included.
    for (i = 0; i < 40; i++) op($urandom % 2, $urandom % 8, $urandom, 1'b0);
    lv();
    // Soft reset keeps configuration and pointers.
    op(1'b1, `RPC_OFS_CONFIG, 8'hb1, 1'b0);
    lv();
    op(1'b0, `RPC_OFS_CONFIG, 8'h00, 1'b0);
    op(1'b0, `RPC_OFS_PTR_UPPER, 8'h00, 1'b0);
    op(1'b0, `RPC_OFS_PTR_LOWER, 8'h00, 1'b0);
    op(1'b1, `RPC_OFS_CONFIG, 8'h31, 1'b0);
    lv();
    // A second hardware reset in mid-run.
    rst(2);
    lv();
    op(1'b0, `RPC_OFS_CONFIG, 8'h00, 1'b0);
    print_verdict();
  end
endmodule : ram_pointer_and_config_regs_tb

`default_nettype wire
